//--- verilog/seq_defs.svh
/*
 * Timing counts and fixed values for the start-up and role sequencer.
 * Assumes a 40 MHz clock; included by the sequencer and the bus watchdog.
 */
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_FREQ_HZ 40000000
// ----------------------------------------
// Times and sizes
// ----------------------------------------
`define PG_LOW_TIME_US 10
`define PG_LOW_CYCLES ((`PG_LOW_TIME_US * `CLK_FREQ_HZ) / 1000000)
`define BUS_TIMEOUT_MS 38
`define BUS_TIMEOUT_CYCLES ((`BUS_TIMEOUT_MS * `CLK_FREQ_HZ) / 1000)
`define FUSE_WORDS 16
`define CHECK_CYCLES 64
`define SLAVE_BOOT_CYCLES 4000
`define BUTTON_DEBOUNCE_CYCLES 255
`define OFF_CYCLES 400
`define PHASE_DIV 40
`define CNT_W 24

`endif

//--- verilog/seq_pkg.sv
/*
 * Types shared by the sequencer files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package seq_pkg;
   typedef enum logic [1:0] {
      ROLE_STANDALONE,
      ROLE_MASTER,
      ROLE_SLAVE
   } role_e;
   typedef enum logic [2:0] {
      ST_LOAD,
      ST_CHECK,
      ST_WAIT_SLAVE,
      ST_POWER_DOWN,
      ST_ACTIVE,
      ST_PG_DROP,
      ST_OFF
   } seq_state_e;
   typedef logic [7:0] fuse_word_t;
endpackage

//--- verilog/seq_bus_watch.sv
/*
 * Serial clock period watchdog: flags a bus timeout when the clock
 * stays in one level for too long.
 * Assumes the serial clock input is already synchronised.
 */
`timescale 1ns/100ps
`default_nettype none
`include "seq_defs.svh"

module seq_bus_watch #(
   parameter logic [23:0] TIMEOUT_CYCLES = 24'(`BUS_TIMEOUT_CYCLES)
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic enable,
   input wire logic scl_sync,
   output logic timeout
);
   logic [23:0] cnt_ff;
   logic last_ff;
   logic timeout_ff;
   logic edge_seen;

   assign edge_seen = scl_sync ^ last_ff;
   assign timeout = timeout_ff;

   // Count the cycles since the last clock edge; one pulse when the count reaches the timeout, then it holds
   always_ff @(posedge clock) begin
      if (srst || !enable || edge_seen) begin
         cnt_ff <= 24'h000000;
         timeout_ff <= 1'b0;
      end else begin
         cnt_ff <= (cnt_ff == TIMEOUT_CYCLES) ? cnt_ff : cnt_ff + 24'h000001;
         timeout_ff <= (cnt_ff == TIMEOUT_CYCLES - 24'h000001);
      end
      last_ff <= srst ? 1'b0 : scl_sync;
   end
endmodule
`default_nettype wire

//--- verilog/startup_role_sequencer.sv
/*
 * Start-up and role sequencer: fuse copy, self-check, role latch,
 * power-down / active control, pair link drive, power cycling.
 * Assumes a 40 MHz clock, a fuse array read port with one-cycle latency,
 * and that pin inputs come straight from pads.
 */
`timescale 1ns/100ps
`default_nettype none
`include "seq_defs.svh"

module startup_role_sequencer #(
   parameter logic [23:0] SLAVE_BOOT_CYCLES = 24'(`SLAVE_BOOT_CYCLES),
   parameter logic [23:0] BUS_TIMEOUT_CYCLES = 24'(`BUS_TIMEOUT_CYCLES)
) (
   input wire logic clock,
   input wire logic srst,
   // Fuse array read port
   output logic [3:0] fuse_addr,
   input wire seq_pkg::fuse_word_t fuse_data,
   // Fuse-derived configuration, held copies
   output logic pair_role_enable,
   output logic boot_to_active_select,
   output logic bus_timeout_enable,
   output logic fixed_freq_mode,
   output logic [3:0] fuse_image_sel,
   input wire logic [1:0] image_index,
   output logic [7:0] image_word,
   // Host overrides over the optional serial bus
   input wire logic host_cfg_valid,
   input wire logic host_fixed_freq,
   input wire logic [1:0] host_pin1_func,
   input wire logic host_irq_on_pin1,
   // Pins and status
   input wire logic power_button_input_n,
   input wire logic gpio1_in,
   input wire logic gpio0_in,
   input wire logic scl_in,
   input wire logic critical_fault,
   input wire logic check_stable,
   input wire logic irq_pending,
   output logic gpio0_out,
   output logic gpio0_oe,
   output logic gpio0_pulldown,
   output logic gpio1_out,
   output logic gpio1_oe,
   output logic [1:0] pin1_func,
   output logic interrupt_request_output,
   output logic power_good_output,
   output logic converter_enable,
   output logic converter_phase,
   output logic osc_enable,
   output logic bus_timeout,
   output seq_pkg::role_e role,
   output seq_pkg::seq_state_e state,
   output logic power_cycle_busy
);
   import seq_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] sync1_ff;
   logic [3:0] sync2_ff;

   // Two stages for every pad input before any logic reads it
   always_ff @(posedge clock) begin
      sync1_ff <= {scl_in, gpio0_in, gpio1_in, power_button_input_n};
      sync2_ff <= sync1_ff;
   end

   logic button_n_s;
   logic gpio1_s;
   logic gpio0_s;
   logic scl_s;
   assign button_n_s = sync2_ff[0];
   assign gpio1_s = sync2_ff[1];
   assign gpio0_s = sync2_ff[2];
   assign scl_s = sync2_ff[3];

   // ----------------------------------------
   // Fuse image
   // ----------------------------------------
   fuse_word_t image_ff [`FUSE_WORDS];
   logic [4:0] load_idx_ff;
   logic load_pend_ff;
   seq_state_e state_ff;
   seq_state_e nxt_state;
   role_e role_ff;
   logic [23:0] cnt_ff;
   logic [23:0] nxt_cnt;

   // Fuse word 0 holds the configuration bits
   logic cfg_pair;
   logic cfg_boot;
   logic cfg_timeout;
   logic cfg_fixed;
   assign cfg_pair = image_ff[0][0];
   assign cfg_boot = image_ff[0][1];
   assign cfg_timeout = image_ff[0][2];
   assign cfg_fixed = image_ff[0][3];

   assign fuse_addr = load_idx_ff[3:0];
   assign image_word = image_ff[{2'b00, image_index}];
   assign fuse_image_sel = image_ff[1][3:0];

   // Copy every fuse word; data arrives one cycle after its address
   always_ff @(posedge clock) begin
      if (srst) begin
         load_idx_ff <= 5'h00;
         load_pend_ff <= 1'b0;
      end else if (state_ff == ST_LOAD && load_idx_ff != 5'(`FUSE_WORDS)) begin
         load_idx_ff <= load_idx_ff + 5'h01;
         load_pend_ff <= 1'b1;
      end else begin
         load_pend_ff <= 1'b0;
      end
   end

   generate
      for (genvar i = 0; i < `FUSE_WORDS; i++) begin : g_img
         always_ff @(posedge clock) begin
            if (srst) begin
               image_ff[i] <= 8'h00;
            end else if (load_pend_ff && load_idx_ff == 5'(i + 1)) begin
               image_ff[i] <= fuse_data;
            end
         end
      end
   endgenerate

   logic load_done;
   assign load_done = state_ff == ST_LOAD && load_idx_ff == 5'(`FUSE_WORDS) && !load_pend_ff;

   // ----------------------------------------
   // Role latch
   // ----------------------------------------
   // Sampled once at load completion; pin one is ignored afterwards
   // so a glitch on the strap cannot flip a running pair.
   role_e role_sel;
   logic role_set_ff;
   assign role_sel = !cfg_pair ? ROLE_STANDALONE :
                     gpio1_s ? ROLE_SLAVE : ROLE_MASTER;

   always_ff @(posedge clock) begin
      if (srst) begin
         role_ff <= ROLE_STANDALONE;
         role_set_ff <= 1'b0;
      end else if (load_done && !role_set_ff) begin
         // A power cycle passes the load state again but must not relatch
         role_ff <= role_sel;
         role_set_ff <= 1'b1;
      end
   end

   // ----------------------------------------
   // Button debounce and press detection
   // ----------------------------------------
   logic [7:0] deb_cnt_ff;
   logic button_ff;
   logic button_prev_ff;
   logic press;

   // A level must stay for the full debounce time before it counts
   always_ff @(posedge clock) begin
      if (srst) begin
         deb_cnt_ff <= 8'h00;
         button_ff <= 1'b1;
         button_prev_ff <= 1'b1;
      end else begin
         button_prev_ff <= button_ff;
         if (button_n_s == button_ff) begin
            deb_cnt_ff <= 8'h00;
         end else if (deb_cnt_ff == 8'(`BUTTON_DEBOUNCE_CYCLES)) begin
            button_ff <= button_n_s;
            deb_cnt_ff <= 8'h00;
         end else begin
            deb_cnt_ff <= deb_cnt_ff + 8'h01;
         end
      end
   end
   assign press = button_prev_ff && !button_ff;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   logic fault_req;
   assign fault_req = critical_fault && (state_ff == ST_ACTIVE || state_ff == ST_POWER_DOWN);

   // Next state and the shared wait counter
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + 24'h000001;
      case (state_ff)
         ST_LOAD: begin
            nxt_cnt = 24'h000000;
            if (load_done) begin
               nxt_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (!check_stable) begin
               nxt_cnt = 24'h000000;
            end else if (cnt_ff == 24'(`CHECK_CYCLES)) begin
               nxt_cnt = 24'h000000;
               if (role_ff == ROLE_SLAVE) begin
                  nxt_state = ST_POWER_DOWN;
               end else if (role_ff == ROLE_MASTER) begin
                  nxt_state = ST_WAIT_SLAVE;
               end else begin
                  nxt_state = cfg_boot ? ST_ACTIVE : ST_POWER_DOWN;
               end
            end
         end
         ST_WAIT_SLAVE: begin
            if (cnt_ff == SLAVE_BOOT_CYCLES) begin
               nxt_cnt = 24'h000000;
               nxt_state = cfg_boot ? ST_ACTIVE : ST_POWER_DOWN;
            end
         end
         ST_POWER_DOWN: begin
            nxt_cnt = 24'h000000;
            if (fault_req) begin
               nxt_state = ST_PG_DROP;
            end else if (press && role_ff != ROLE_SLAVE) begin
               nxt_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            nxt_cnt = 24'h000000;
            if (fault_req) begin
               nxt_state = ST_PG_DROP;
            end
         end
         ST_PG_DROP: begin
            if (cnt_ff == 24'(`PG_LOW_CYCLES - 1)) begin
               nxt_cnt = 24'h000000;
               nxt_state = ST_OFF;
            end
         end
         ST_OFF: begin
            if (cnt_ff == 24'(`OFF_CYCLES)) begin
               nxt_cnt = 24'h000000;
               nxt_state = ST_LOAD;
            end
         end
         default: begin
            nxt_state = ST_LOAD;
            nxt_cnt = 24'h000000;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_ff <= ST_LOAD;
         cnt_ff <= 24'h000000;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Leaving the off state returns to the load state but does not copy the fuses again:
   // the copy index is only reset by srst, so the load completes at once
   logic reload;
   assign reload = state_ff == ST_OFF && nxt_state == ST_LOAD;

   // ----------------------------------------
   // Converter and pair link
   // ----------------------------------------
   logic active;
   logic fixed_sel;
   logic [5:0] ph_cnt_ff;
   logic phase_ff;
   logic link_ff;
   assign active = state_ff == ST_ACTIVE;
   assign fixed_sel = host_cfg_valid ? host_fixed_freq : cfg_fixed;

   // Phase clock for the converter; only runs while active
   always_ff @(posedge clock) begin
      if (srst || !active) begin
         ph_cnt_ff <= 6'h00;
         phase_ff <= 1'b0;
      end else if (ph_cnt_ff == 6'(`PHASE_DIV - 1)) begin
         ph_cnt_ff <= 6'h00;
         phase_ff <= !phase_ff;
      end else begin
         ph_cnt_ff <= ph_cnt_ff + 6'h01;
      end
   end

   // Link carries phase while the master converter runs, low otherwise
   always_ff @(posedge clock) begin
      if (srst) begin
         link_ff <= 1'b0;
      end else begin
         link_ff <= active && role_ff == ROLE_MASTER && phase_ff;
      end
   end

   // A slave follows the link; others follow their own state
   assign converter_enable = role_ff == ROLE_SLAVE ? gpio0_s : active;
   assign converter_phase = role_ff == ROLE_SLAVE ? gpio0_s : phase_ff;
   assign gpio0_out = link_ff;
   assign gpio0_oe = role_ff == ROLE_MASTER && active;
   assign gpio0_pulldown = cfg_pair && state_ff != ST_LOAD;

   // ----------------------------------------
   // General pin one and interrupt
   // ----------------------------------------
   // Pin one is a strap on a slave, so it is never driven there
   assign pin1_func = host_cfg_valid ? host_pin1_func : 2'b00;
   assign gpio1_out = !irq_pending;
   assign gpio1_oe = role_ff != ROLE_SLAVE && host_cfg_valid && host_irq_on_pin1;
   assign interrupt_request_output = !irq_pending;

   // ----------------------------------------
   // Status
   // ----------------------------------------
   assign power_good_output = active;
   assign osc_enable = state_ff != ST_POWER_DOWN || !button_ff || deb_cnt_ff != 8'h00;
   assign pair_role_enable = cfg_pair;
   assign boot_to_active_select = cfg_boot;
   assign bus_timeout_enable = cfg_timeout;
   assign fixed_freq_mode = fixed_sel;
   assign role = role_ff;
   assign state = state_ff;
   assign power_cycle_busy = state_ff == ST_PG_DROP || state_ff == ST_OFF || reload;

   seq_bus_watch #(
      .TIMEOUT_CYCLES(BUS_TIMEOUT_CYCLES)
   ) u_watch (
      .clock(clock),
      .srst(srst),
      .enable(cfg_timeout && role_ff != ROLE_SLAVE),
      .scl_sync(scl_s),
      .timeout(bus_timeout)
   );
endmodule
`default_nettype wire

//--- dv/fuse_rom_model.sv
/*
 * Fuse array model behind the sequencer read port.
 * Assumes the bench sets words 0 and 1 before each load.
 */
`timescale 1ns/100ps
`default_nettype none

module fuse_rom_model (
   input wire logic clock,
   input wire logic [3:0] fuse_addr,
   input wire seq_pkg::fuse_word_t word0,
   input wire seq_pkg::fuse_word_t word1,
   output seq_pkg::fuse_word_t fuse_data
);
   import seq_pkg::*;
   fuse_word_t nxt_data;
   fuse_word_t data_ff;
   // Upper words carry their address, so a misplaced copy shows up
   assign nxt_data = (fuse_addr[3:1] != 3'h0) ? {4'hA, fuse_addr} : (fuse_addr[0] ? word1 : word0);
   assign fuse_data = data_ff;
   // One cycle read latency, like the real array
   always_ff @(posedge clock) begin
      data_ff <= nxt_data;
   end
endmodule
`default_nettype wire

//--- dv/seq_sva.sv
/*
 * Port assertions for the start-up and role sequencer.
 * Assumes binding into startup_role_sequencer with its parameters.
 */
`timescale 1ns/100ps
`default_nettype none

module seq_sva #(
   parameter logic [23:0] SLAVE_BOOT_CYCLES = 24'h000FA0,
   parameter logic [23:0] BUS_TIMEOUT_CYCLES = 24'h173180
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic critical_fault,
   input wire logic bus_timeout_enable,
   input wire logic gpio0_oe,
   input wire logic power_good_output,
   input wire logic osc_enable,
   input wire logic bus_timeout,
   input wire seq_pkg::role_e role,
   input wire seq_pkg::seq_state_e state
);
   import seq_pkg::*;
   seq_state_e state_ff;
   logic [23:0] dwell_ff;
   logic [23:0] nxt_dwell;
   logic leaving;
   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);

   // ----------------------------------------
   // Dwell counter
   // ----------------------------------------
   // Length of the stay in state_ff, valid on the edge that leaves it
   assign leaving = (state != state_ff);
   assign nxt_dwell = leaving ? 24'h000001 : dwell_ff + 24'h000001;
   always_ff @(posedge clock) begin
      if (srst) begin
         state_ff <= ST_LOAD;
         dwell_ff <= 24'h000000;
      end else begin
         state_ff <= state;
         dwell_ff <= nxt_dwell;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_pg_only_active: assert property (power_good_output |-> state == ST_ACTIVE)
      else $error("power good outside active");
   chk_pg_drop_len: assert property (state_ff == ST_PG_DROP && leaving |->
      dwell_ff == 24'h000190 && state == ST_OFF) else $error("power good drop length");
   chk_slave_wait: assert property (state_ff == ST_WAIT_SLAVE && leaving |->
      dwell_ff == SLAVE_BOOT_CYCLES + 24'h000001 && state == ST_ACTIVE) else $error("slave wait");
   chk_fault_entry: assert property (critical_fault &&
      (state == ST_ACTIVE || state == ST_POWER_DOWN) |=> state == ST_PG_DROP) else $error("fault");
   chk_role_hold: assert property (state != ST_LOAD && $past(state) != ST_LOAD |->
      $stable(role)) else $error("role changed");
   chk_link_drive: assert property (
      gpio0_oe == (role == ROLE_MASTER && state == ST_ACTIVE)) else $error("link enable");
   chk_osc_need: assert property (!osc_enable |-> state == ST_POWER_DOWN)
      else $error("oscillator off");
   chk_timeout_pulse: assert property (
      bus_timeout |-> bus_timeout_enable ##1 !bus_timeout) else $error("timeout pulse");
   cover property (state == ST_ACTIVE && role == ROLE_MASTER);
   cover property (state == ST_PG_DROP);
   cover property (bus_timeout);
endmodule

bind startup_role_sequencer seq_sva #(.SLAVE_BOOT_CYCLES(SLAVE_BOOT_CYCLES),
   .BUS_TIMEOUT_CYCLES(BUS_TIMEOUT_CYCLES)) chk_u (.clock, .srst, .critical_fault,
   .bus_timeout_enable, .gpio0_oe, .power_good_output, .osc_enable, .bus_timeout, .role, .state);
`default_nettype wire

//--- dv/testbench.sv
/*
 * Self-checking bench for the start-up and role sequencer.
 * Assumes the fuse model and the bound checker are compiled with it.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, a); end end

module testbench;
   import seq_pkg::*;
   typedef struct {logic [3:0] w; logic s; role_e r; seq_state_e st; logic pd;} row_s;
   // Fuse nibble and strap beside the role, resting state and pull-down they give
   row_s rows [4] = '{'{4'h0, 1'b0, ROLE_STANDALONE, ST_POWER_DOWN, 1'b0},
      '{4'hA, 1'b0, ROLE_STANDALONE, ST_ACTIVE, 1'b0},
      '{4'h3, 1'b1, ROLE_SLAVE, ST_POWER_DOWN, 1'b1},
      '{4'hB, 1'b0, ROLE_MASTER, ST_ACTIVE, 1'b1}};
   logic clock = 1'b0, srst = 1'b1, check_stable = 1'b1;
   fuse_word_t cfg0 = 8'h00, cfg1 = 8'h05, fuse_data;
   logic [3:0] fuse_addr, fuse_image_sel;
   logic [1:0] image_index = 2'h0, host_pin1_func = 2'h0, pin1_func;
   logic [7:0] image_word;
   logic host_cfg_valid = 1'b0, host_fixed_freq = 1'b0, host_irq_on_pin1 = 1'b0;
   logic power_button_input_n = 1'b1, gpio1_in = 1'b0, gpio0_in = 1'b0, scl_in = 1'b0;
   logic critical_fault = 1'b0, irq_pending = 1'b0, p;
   logic pair_role_enable, boot_to_active_select, bus_timeout_enable, fixed_freq_mode;
   logic gpio0_out, gpio0_oe, gpio0_pulldown, gpio1_out, gpio1_oe, interrupt_request_output;
   logic power_good_output, converter_enable, converter_phase, osc_enable, bus_timeout;
   logic power_cycle_busy;
   role_e role;
   seq_state_e state;
   int bad_count = 0, n_checks = 0, to_cnt = 0;

   // Short slave wait and bus timeout keep the run brief
   startup_role_sequencer #(.SLAVE_BOOT_CYCLES(24'h000032), .BUS_TIMEOUT_CYCLES(24'h000064))
      dut_u (.clock, .srst, .fuse_addr, .fuse_data, .pair_role_enable, .boot_to_active_select,
      .bus_timeout_enable, .fixed_freq_mode, .fuse_image_sel, .image_index, .image_word,
      .host_cfg_valid, .host_fixed_freq, .host_pin1_func, .host_irq_on_pin1,
      .power_button_input_n, .gpio1_in, .gpio0_in, .scl_in, .critical_fault, .check_stable,
      .irq_pending, .gpio0_out, .gpio0_oe, .gpio0_pulldown, .gpio1_out, .gpio1_oe, .pin1_func,
      .interrupt_request_output, .power_good_output, .converter_enable, .converter_phase,
      .osc_enable, .bus_timeout, .role, .state, .power_cycle_busy);
   fuse_rom_model fuse_u (.clock, .fuse_addr, .word0(cfg0), .word1(cfg1), .fuse_data);

   // 40 MHz clock
   always #12.5 clock = ~clock;
   // Timeout pulses seen; scenarios clear it between edges
   always @(posedge clock) begin
      if (bus_timeout === 1'b1) begin
         to_cnt++;
      end
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Bounded wait for a state
   task automatic wait_st(input seq_state_e s, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clock);
         if (state === s) break;
      end
   endtask

   // Cold boot: reset for 4 cycles, then wait for a resting state
   task automatic boot(input logic [3:0] w, input logic s);
      @(posedge clock);
      srst <= 1'b1;
      cfg0 <= {4'h0, w};
      gpio1_in <= s;
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      for (int i = 0; i < 400; i++) begin
         @(negedge clock);
         if (state === ST_ACTIVE || state === ST_POWER_DOWN) break;
      end
      to_cnt = 0;
   endtask

   // Hold the button down; long enough to pass sync and debounce
   task automatic press(input int n);
      @(posedge clock);
      power_button_input_n <= 1'b0;
      repeat (n) @(posedge clock);
      power_button_input_n <= 1'b1;
      @(negedge clock);
   endtask

   // Watchdog, well past the expected run length
   initial begin
      repeat (10000) @(posedge clock);
      bad_count++;
      give_verdict();
   end

   initial begin
      foreach (rows[i]) begin
         boot(rows[i].w, rows[i].s);
         `CHK("role", rows[i].r, role)
         `CHK("state", rows[i].st, state)
         `CHK("pg", rows[i].st == ST_ACTIVE, power_good_output)
         `CHK("pulldown", rows[i].pd, gpio0_pulldown)
         `CHK("pair", rows[i].w[0], pair_role_enable)
         `CHK("boot_sel", rows[i].w[1], boot_to_active_select)
         `CHK("fixed", rows[i].w[3], fixed_freq_mode)
         `CHK("osc", rows[i].st != ST_POWER_DOWN, osc_enable)
      end
      // Master active: image readback, link phase, host overrides
      @(posedge clock);
      image_index <= 2'h2;
      repeat (2) @(negedge clock);
      `CHK("image", 8'hA2, image_word)
      `CHK("img_sel", 4'h5, fuse_image_sel)
      `CHK("conv_en", 1'b1, converter_enable)
      `CHK("link_oe", 1'b1, gpio0_oe)
      p = gpio0_out;
      repeat (40) @(negedge clock);
      `CHK("phase", ~p, gpio0_out)
      @(posedge clock);
      host_cfg_valid <= 1'b1;
      host_pin1_func <= 2'h2;
      host_irq_on_pin1 <= 1'b1;
      irq_pending <= 1'b1;
      repeat (2) @(negedge clock);
      `CHK("fixed", 1'b0, fixed_freq_mode)
      `CHK("pin1_func", 2'h2, pin1_func)
      `CHK("pin1_oe", 1'b1, gpio1_oe)
      `CHK("pin1_out", 1'b0, gpio1_out)
      `CHK("irq", 1'b0, interrupt_request_output)
      // Fault with the strap moved: power cycle, role kept
      @(posedge clock);
      critical_fault <= 1'b1;
      gpio1_in <= 1'b1;
      @(posedge clock);
      critical_fault <= 1'b0;
      @(negedge clock);
      `CHK("state", ST_PG_DROP, state)
      `CHK("pg", 1'b0, power_good_output)
      `CHK("busy", 1'b1, power_cycle_busy)
      repeat (398) @(negedge clock);
      `CHK("state", ST_PG_DROP, state)
      repeat (3) @(negedge clock);
      `CHK("state", ST_OFF, state)
      wait_st(ST_ACTIVE, 1000);
      `CHK("state", ST_ACTIVE, state)
      `CHK("role", ROLE_MASTER, role)
      `CHK("busy", 1'b0, power_cycle_busy)
      // Unstable supply holds the self-check; stability then lets it finish
      @(posedge clock);
      check_stable <= 1'b0;
      boot(4'h0, 1'b0);
      `CHK("state", ST_CHECK, state)
      @(posedge clock);
      check_stable <= 1'b1;
      wait_st(ST_POWER_DOWN, 100);
      `CHK("state", ST_POWER_DOWN, state)
      // Standalone wake by button, no timeout while disabled
      boot(4'h0, 1'b0);
      press(300);
      `CHK("state", ST_ACTIVE, state)
      `CHK("timeouts", 0, to_cnt)
      // Slave ignores the button and follows the link
      boot(4'h3, 1'b1);
      press(300);
      `CHK("state", ST_POWER_DOWN, state)
      for (int v = 1; v >= 0; v--) begin
         @(posedge clock);
         gpio0_in <= v[0];
         repeat (4) @(negedge clock);
         `CHK("conv_en", v[0], converter_enable)
         `CHK("conv_ph", v[0], converter_phase)
         `CHK("link_oe", 1'b0, gpio0_oe)
      end
      // Serial clock watchdog: toggling keeps it quiet, stillness fires once
      boot(4'h6, 1'b0);
      `CHK("to_en", 1'b1, bus_timeout_enable)
      @(posedge clock);
      scl_in <= 1'b1;
      @(negedge clock);
      to_cnt = 0;
      repeat (6) begin
         repeat (50) @(posedge clock);
         scl_in <= ~scl_in;
      end
      @(negedge clock);
      `CHK("timeouts", 0, to_cnt)
      repeat (130) @(negedge clock);
      `CHK("timeouts", 1, to_cnt)
      give_verdict();
   end
endmodule
`default_nettype wire
